// File: hw/display_ram.sv
// display data memory, one write port and two registered read ports
`timescale 1ns/10ps
module display_ram #(
    parameter int DEPTH = 576,
    parameter int WIDTH = 8,
    parameter int AW = 10
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read ports
    input wire logic [AW-1:0] rd_a_addr,
    output logic [WIDTH-1:0] rd_a_data,
    input wire logic [AW-1:0] rd_b_addr,
    output logic [WIDTH-1:0] rd_b_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end
endmodule : display_ram

// File: hw/frame_divider.sv
// frame signal divider and common step counter on the operating tick
`timescale 1ns/10ps
module frame_divider
    import lcd_timing_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // control
    input wire logic en,
    input wire logic tick,
    input wire logic [4:0] frm,
    input wire logic [4:0] duty,
    // timing outputs
    output logic frame_q,
    output logic frame_evt_q,
    output logic step_evt_q,
    output logic [4:0] com_idx_q
);
    logic [11:0] cnt_q;
    logic [7:0] step_q;
    wire [11:0] prod = 12'(6'(frm) + 6'h01) * 12'(6'(duty) + 6'h01);
    wire [11:0] half_term = 12'(prod * 12'(FRAME_PHASES / 2)) - 12'h001;
    wire [7:0] step_term = {frm, 3'h7};
    wire wrap = tick && (cnt_q >= half_term);
    wire rise = wrap && !frame_q;

    // half period counter, frame toggles at each wrap
    always_ff @(posedge core_clk) begin
        if (!nrst || !en) begin
            cnt_q <= 12'h000;
            frame_q <= 1'b0;
            frame_evt_q <= 1'b0;
        end else begin
            frame_evt_q <= rise;
            if (wrap) begin
                cnt_q <= 12'h000;
                frame_q <= !frame_q;
            end else if (tick) begin
                cnt_q <= cnt_q + 12'h001;
            end
        end
    end

    // each common holds 8*(frm+1) ticks; realigned at frame start
    always_ff @(posedge core_clk) begin
        if (!nrst || !en) begin
            step_q <= 8'h00;
            com_idx_q <= 5'h00;
            step_evt_q <= 1'b0;
        end else begin
            step_evt_q <= rise || (tick && step_q >= step_term);
            if (rise) begin
                step_q <= 8'h00;
                com_idx_q <= 5'h00;
            end else if (tick && step_q >= step_term) begin
                step_q <= 8'h00;
                com_idx_q <= (com_idx_q >= duty) ? 5'h00 : com_idx_q + 5'h01;
            end else if (tick) begin
                step_q <= step_q + 8'h01;
            end
        end
    end

    AST_FRAME_EVT: assert property (@(posedge core_clk) disable iff (!nrst)
        frame_evt_q |-> frame_q && !$past(frame_q))
        else $error("frame event without frame rise");
    AST_CNT_BOUND: assert property (@(posedge core_clk) disable iff (!nrst)
        (tick && en) |=> cnt_q <= $past(half_term))
        else $error("frame counter beyond terminal count");
    AST_FRAME_COM0: assert property (@(posedge core_clk) disable iff (!nrst)
        frame_evt_q |-> com_idx_q == 5'h00 && step_q == 8'h00)
        else $error("frame start not aligned to first common");
endmodule : frame_divider

// File: hw/lcd_frame_timing_clock.sv
// segment panel clocking, frame timing, scan and register slave
// What this block does
// - frame rate is operating clock over 8*(frame divider+1)*(duty+1).
// - frame divider setting is five bits, thirty-two ratios 0 to 31.
// - duty setting 0 to 23 means 1/(k+1) duty in the division.
// - with debug run clear, operating clock stops during cpu debug, resumes after.
// - while stopped for debug, block halts, display blanks, registers keep values.
// - with debug run set, block keeps running through cpu debug.
// - frame signal appears on frame monitor pin, low out of reset.
// - an interrupt request can be raised once each frame.
// - 72 segs for 1-8 commons, 64 for 9-16, 56 for 17-24.
// - display data memory holds 576 bytes of segment pattern.
`timescale 1ns/10ps
module lcd_frame_timing_clock
    import lcd_timing_pkg::*;
#(
    parameter int SRC_PRESCALE0 = OP_PRESCALE,
    parameter int SRC_PRESCALE1 = OP_PRESCALE,
    parameter int SRC_PRESCALE2 = OP_PRESCALE,
    parameter int SRC_PRESCALE3 = OP_PRESCALE
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // axi4-lite write
    input wire logic [12:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [12:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu state pin
    input wire logic cpu_debug,
    // interrupt
    output logic irq,
    // panel side
    output logic frame_monitor_out,
    output logic panel_bias_on,
    output logic [COM_MAX-1:0] com_out,
    output logic [SEG_MAX-1:0] seg_out
);
    logic [1:0] clock_source_select_q;
    logic [2:0] clock_divide_select_q;
    logic debug_run_keep_q;
    logic [4:0] drive_duty_setting_q;
    logic [4:0] frame_divider_setting_q;
    logic module_enable_q;
    logic stat_q;
    logic mask_q;
    logic irq_q;
    logic [2:0] dbg_sync_q;
    logic dbg_q;
    logic [9:0] pre_q;
    logic [6:0] oct_q;
    logic tick_q;
    logic [12:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [12:0] ar_addr_q;
    logic rd_stage_q;
    scan_state_type scan_st_q;
    logic [6:0] scan_k_q;
    logic [4:0] scan_com_q;
    logic [SEG_MAX-1:0] shadow_q;
    logic [COM_MAX-1:0] com_q;
    logic [SEG_MAX-1:0] seg_q;
    logic frame_sig;
    logic frame_evt;
    logic step_evt;
    logic [4:0] com_idx;
    logic [7:0] ram_a_data;
    logic [7:0] ram_b_data;

    // debug pin: a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dbg_sync_q <= 3'h0;
            dbg_q <= 1'b0;
        end else begin
            dbg_sync_q <= {dbg_sync_q[1:0], cpu_debug};
            if (dbg_sync_q[1] == dbg_sync_q[2]) begin
                dbg_q <= dbg_sync_q[2];
            end
        end
    end

    // suspension gates the operating tick and blanks the display; registers are untouched
    wire suspended = module_enable_q && dbg_q && !debug_run_keep_q;
    wire running = module_enable_q && !suspended;

    // operating clock as a tick: source prescale, then power-of-two divide
    wire [9:0] src_term = (clock_source_select_q == 2'h0) ? 10'(SRC_PRESCALE0 - 1) :
                          (clock_source_select_q == 2'h1) ? 10'(SRC_PRESCALE1 - 1) :
                          (clock_source_select_q == 2'h2) ? 10'(SRC_PRESCALE2 - 1) :
                          10'(SRC_PRESCALE3 - 1);
    wire pre_wrap = pre_q >= src_term;
    wire [7:0] div_mask8 = (8'h01 << clock_divide_select_q) - 8'h01;
    wire [6:0] div_mask = div_mask8[6:0];
    wire tick_d = running && pre_wrap && ((oct_q & div_mask) == div_mask);

    always_ff @(posedge core_clk) begin
        if (!nrst || !running) begin
            pre_q <= 10'h000;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 10'h000 : pre_q + 10'h001;
            tick_q <= tick_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst || !module_enable_q) begin
            oct_q <= 7'h00;
        end else if (running && pre_wrap) begin
            oct_q <= oct_q + 7'h01;
        end
    end

    wire [4:0] duty_eff = (drive_duty_setting_q > DUTY_MAX) ? DUTY_MAX
                                                            : drive_duty_setting_q;

    frame_divider u_frame (
        .core_clk(core_clk),
        .nrst(nrst),
        .en(module_enable_q),
        .tick(tick_q && running),
        .frm(frame_divider_setting_q),
        .duty(duty_eff),
        .frame_q(frame_sig),
        .frame_evt_q(frame_evt),
        .step_evt_q(step_evt),
        .com_idx_q(com_idx)
    );

    // segment capacity follows the number of commons
    wire [6:0] seg_limit = (duty_eff <= DUTY_8COM) ? 7'(SEG_MAX) :
                           (duty_eff <= DUTY_16COM) ? 7'(SEG_MID) : 7'(SEG_MIN);
    logic [SEG_MAX-1:0] seg_mask;
    genvar gi;
    generate
        for (gi = 0; gi < SEG_MAX; gi++) begin : g_seg
            assign seg_mask[gi] = 7'(gi) < seg_limit;
        end
    endgenerate

    // scan: fetch one common's pattern at core rate, far inside one tick
    wire [9:0] scan_addr = 10'(10'(scan_com_q[4:3]) * 10'(SEG_MAX)) + 10'(scan_k_q);
    wire scan_bit = ram_b_data[scan_com_q[2:0]];

    always_ff @(posedge core_clk) begin
        if (!nrst || !running) begin
            scan_st_q <= SCAN_IDLE;
            scan_k_q <= 7'h00;
            scan_com_q <= 5'h00;
            shadow_q <= '0;
            com_q <= '0;
            seg_q <= '0;
        end else begin
            case (scan_st_q)
                SCAN_IDLE: begin
                    if (step_evt) begin
                        scan_st_q <= SCAN_FETCH;
                        scan_k_q <= 7'h00;
                        scan_com_q <= com_idx;
                    end
                end
                SCAN_FETCH: begin
                    if (scan_k_q != 7'h00) begin
                        shadow_q[scan_k_q - 7'h01] <= scan_bit;
                    end
                    if (scan_k_q == 7'(SEG_MAX)) begin
                        scan_st_q <= SCAN_LATCH;
                    end else begin
                        scan_k_q <= scan_k_q + 7'h01;
                    end
                end
                SCAN_LATCH: begin
                    seg_q <= shadow_q & seg_mask;
                    com_q <= 24'h000001 << scan_com_q;
                    scan_st_q <= SCAN_IDLE;
                end
                default: begin
                    scan_st_q <= SCAN_IDLE;
                end
            endcase
        end
    end

    // axi4-lite slave: address and data taken in either order
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [12:0] wa = {aw_addr_q[12:2], 2'h0};
    wire [12:0] ra = {ar_addr_q[12:2], 2'h0};
    wire [12:0] ram_top = 13'(ADDR_RAM + 13'(RAM_BYTES * 4));
    wire wa_ram = (wa >= ADDR_RAM) && (wa < ram_top);
    wire ra_ram = (ra >= ADDR_RAM) && (ra < ram_top);
    wire [12:0] wa_off = wa - ADDR_RAM;
    wire [12:0] ar_off = {s_axi_araddr[12:2], 2'h0} - ADDR_RAM;
    wire wr_clk = wr_go && wa == ADDR_CLK;
    wire wr_tim = wr_go && wa == ADDR_TIM;
    wire wr_ctl = wr_go && wa == ADDR_CTL;
    wire wr_intf = wr_go && wa == ADDR_INTF;
    wire wr_inte = wr_go && wa == ADDR_INTE;
    wire wr_ram = wr_go && wa_ram && w_strb_q[0];
    wire wa_ok = wa_ram || wa == ADDR_CLK || wa == ADDR_TIM || wa == ADDR_CTL ||
                 wa == ADDR_INTF || wa == ADDR_INTE || wa == ADDR_STAT;
    wire ra_ok = ra_ram || ra == ADDR_CLK || ra == ADDR_TIM || ra == ADDR_CTL ||
                 ra == ADDR_INTF || ra == ADDR_INTE || ra == ADDR_STAT;
    wire [31:0] rd_word =
        (ra == ADDR_CLK) ? 32'({debug_run_keep_q, 5'h00, clock_divide_select_q,
                                clock_source_select_q}) :
        (ra == ADDR_TIM) ? 32'({frame_divider_setting_q, 3'h0, drive_duty_setting_q}) :
        (ra == ADDR_CTL) ? 32'(module_enable_q) :
        (ra == ADDR_INTF) ? 32'(stat_q) :
        (ra == ADDR_INTE) ? 32'(mask_q) :
        (ra == ADDR_STAT) ? 32'({suspended, 3'h0, com_idx, 7'h00, frame_sig}) :
        ra_ram ? 32'(ram_a_data) : 32'h00000000;

    display_ram #(.DEPTH(RAM_BYTES), .WIDTH(8), .AW(10)) u_ram (
        .clk(core_clk),
        .wr_en(wr_ram),
        .wr_addr(wa_off[11:2]),
        .wr_data(w_data_q[7:0]),
        .rd_a_addr(ar_off[11:2]),
        .rd_a_data(ram_a_data),
        .rd_b_addr(scan_addr),
        .rd_b_data(ram_b_data)
    );

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_q <= 13'h0000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            ar_addr_q <= 13'h0000;
            rd_stage_q <= 1'b0;
        end else begin
            rd_stage_q <= ar_hs;
            if (ar_hs) begin
                ar_addr_q <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (rd_stage_q) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // control registers; low byte lane carries every field but the frame divider and the debug run keep bit
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            clock_source_select_q <= 2'h0;
            clock_divide_select_q <= 3'h0;
            debug_run_keep_q <= 1'b0;
            drive_duty_setting_q <= 5'h00;
            frame_divider_setting_q <= 5'h00;
            module_enable_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (wr_clk && w_strb_q[0]) begin
                clock_source_select_q <= w_data_q[CLK_SRC_LSB +: 2];
                clock_divide_select_q <= w_data_q[CLK_DIV_LSB +: 3];
            end
            if (wr_clk && w_strb_q[1]) begin
                debug_run_keep_q <= w_data_q[CLK_DEBUG_RUN_KEEP_BIT];
            end
            if (wr_tim && w_strb_q[0]) begin
                drive_duty_setting_q <= w_data_q[TIM_DUTY_LSB +: 5];
            end
            if (wr_tim && w_strb_q[1]) begin
                frame_divider_setting_q <= w_data_q[TIM_FRM_LSB +: 5];
            end
            if (wr_ctl && w_strb_q[0]) begin
                module_enable_q <= w_data_q[CTL_MODULE_ENABLE_BIT];
            end
            if (wr_inte && w_strb_q[0]) begin
                mask_q <= w_data_q[0];
            end
        end
    end

    // sticky frame flag: a new frame event wins over a write-one clear
    wire stat_clr = wr_intf && w_strb_q[0] && w_data_q[0];
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stat_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= frame_evt || (stat_q && !stat_clr);
            irq_q <= stat_q && mask_q;
        end
    end

    assign irq = irq_q;
    assign frame_monitor_out = frame_sig;
    assign com_out = com_q;
    assign seg_out = seg_q;
    assign panel_bias_on = module_enable_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_IRQ_SET: assert property (frame_evt |=> stat_q ##1 (irq_q == $past(mask_q)))
        else $error("frame event did not reach the interrupt");
    AST_SUSP_BLANK: assert property (suspended |=> com_out == '0 && seg_out == '0)
        else $error("display not blanked while suspended");
    AST_SUSP_HOLD: assert property ($past(suspended) && suspended |-> $stable(frame_sig))
        else $error("frame signal moved while suspended");
    AST_SUSP_REGS: assert property (suspended && !wr_go |=> $stable(drive_duty_setting_q))
        else $error("register changed during debug suspension");
    AST_DEBUG_RUN_KEEP_RUNS: assert property (dbg_q && debug_run_keep_q && module_enable_q
        && src_term != 10'h000 |=> pre_q != $past(pre_q)) else $error("debug run halted");
    AST_DISABLED_LOW: assert property (!module_enable_q |=> !frame_monitor_out)
        else $error("frame monitor high while disabled");
    AST_COM_ONEHOT: assert property ($onehot0(com_out))
        else $error("more than one common active");
    AST_SEG_CAP: assert property (running && scan_st_q == SCAN_LATCH && duty_eff > DUTY_16COM
        |=> seg_out[SEG_MAX-1:SEG_MIN] == '0)
        else $error("segment above capacity driven");
    AST_TICK_GATE: assert property (tick_q |-> $past(running))
        else $error("operating tick while halted");

    COV_FRAME: cover property (frame_evt ##1 irq_q [*1]);
    COV_SUSPEND: cover property (running ##1 suspended ##1 suspended);
    COV_SCAN: cover property (scan_st_q == SCAN_LATCH ##1 com_out != '0);
endmodule : lcd_frame_timing_clock

// File: hw/lcd_timing_pkg.sv
// shared constants and types of the panel frame timing block
package lcd_timing_pkg;
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int OP_CLK_HZ = 32_768;
    localparam int OP_PRESCALE = CORE_CLK_HZ / OP_CLK_HZ;
    localparam int FRAME_PHASES = 8;
    localparam int SEG_MAX = 72;
    localparam int SEG_MID = 64;
    localparam int SEG_MIN = 56;
    localparam int COM_MAX = 24;
    localparam int RAM_BYTES = 576;
    localparam logic [4:0] DUTY_MAX = 5'h17;
    localparam logic [4:0] DUTY_8COM = 5'h07;
    localparam logic [4:0] DUTY_16COM = 5'h0f;
    localparam int ADDR_W = 13;
    localparam logic [12:0] ADDR_CLK = 13'h0000;
    localparam logic [12:0] ADDR_TIM = 13'h0004;
    localparam logic [12:0] ADDR_CTL = 13'h0008;
    localparam logic [12:0] ADDR_INTF = 13'h000c;
    localparam logic [12:0] ADDR_INTE = 13'h0010;
    localparam logic [12:0] ADDR_STAT = 13'h0014;
    localparam logic [12:0] ADDR_RAM = 13'h0800;
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_DIV_LSB = 2;
    localparam int CLK_DEBUG_RUN_KEEP_BIT = 8;
    localparam int TIM_DUTY_LSB = 0;
    localparam int TIM_FRM_LSB = 8;
    localparam int CTL_MODULE_ENABLE_BIT = 0;
    localparam int STAT_COM_LSB = 8;
    localparam int STAT_SUSP_BIT = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_FETCH, SCAN_LATCH} scan_state_type;
endpackage : lcd_timing_pkg

// File: verification/panel_model.sv
// panel side model: watches the common drive lines of the glass
`timescale 1ns/10ps
module panel_model
    import lcd_timing_pkg::*;
(
    // panel drive
    input wire logic core_clk,
    input wire logic [COM_MAX-1:0] com_out,
    input wire logic [SEG_MAX-1:0] seg_out,
    // observation
    output logic multi_q
);
    // two commons driven at once would ghost rows on real glass
    initial multi_q = 1'b0;
    always @(posedge core_clk) begin
        // segments driven with no common selected would bias the glass
        if ($countones(com_out) > 1 || (com_out == '0 && seg_out != '0)) begin
            multi_q <= 1'b1;
        end
    end
endmodule : panel_model

// File: verification/tb_top.sv
// self-checking bench for the panel frame timing block
`timescale 1ns/10ps
module tb_top;
    import lcd_timing_pkg::*;
    localparam int PS = 4;
    logic core_clk = 1'b0, nrst = 1'b0, cpu_debug = 1'b0, fr;
    logic [12:0] s_axi_awaddr = 13'h0, s_axi_araddr = 13'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, frame_monitor_out, panel_bias_on, multi_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [COM_MAX-1:0] com_out;
    logic [SEG_MAX-1:0] seg_out;
    int bad_count = 0, checks = 0, seed = 19, n, f, d;

    // source 0 is shortened for run time; source 1 keeps the 32 kHz prescale
    lcd_frame_timing_clock #(.SRC_PRESCALE0(PS)) dut_u (.core_clk, .nrst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cpu_debug, .irq, .frame_monitor_out,
        .panel_bias_on, .com_out, .seg_out);
    panel_model panel_u (.core_clk, .com_out, .seg_out, .multi_q);

    initial forever #20 core_clk = ~core_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // sized for the longest frame sequence plus the display memory fill
    initial begin
        #(40 * 90000);
        bad_count++;
        finish_test();
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [12:0] a, input logic [31:0] dat);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rdr(input logic [12:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : rdr

    function automatic int half(input int fq, input int du, input int dv);
        return 4 * (fq + 1) * (du + 1) * PS * (1 << dv);
    endfunction : half

    // core cycles between two toggles of the frame monitor
    task automatic tog(output int c);
        logic v;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            v = frame_monitor_out;
            while (frame_monitor_out === v && c < 20000) begin
                @(negedge core_clk);
                c++;
            end
        end
    endtask : tog

    initial begin
        repeat (4) @(posedge core_clk);
        chk("frame_rst", frame_monitor_out, 0);
        nrst <= 1'b1;
        wr(13'h0018, 32'h1);
        chk("wr_unmapped", rsp, RESP_SLVERR);
        rdr(13'h0018);
        chk("rd_unmapped", rsp, RESP_SLVERR);
        for (d = 0; d <= 23; d++) begin
            f = $random(seed) & 31;
            wr(ADDR_TIM, 32'(f * 256 + d));
            rdr(ADDR_TIM);
            chk("timing", rd, 32'(f * 256 + d));
        end
        for (n = 0; n < 576; n++) wr(ADDR_RAM + 13'(n * 4), 32'hff);
        f = $random(seed) & 255;
        wr(ADDR_RAM + 13'h08fc, 32'(f));
        rdr(ADDR_RAM + 13'h08fc);
        chk("ram_last", rd[7:0], 32'(f));
        wr(ADDR_CLK, 32'h00);
        wr(ADDR_CTL, 32'h1);
        chk("bias_on", panel_bias_on, 1);
        for (int dv = 0; dv < 2; dv++) begin
            f = $random(seed) & 3;
            d = $random(seed) & 3;
            wr(ADDR_CLK, 32'(dv * 4));
            wr(ADDR_TIM, 32'(f * 256 + d));
            tog(n);
            tog(n);
            chk("half_frame", n, half(f, d, dv));
        end
        wr(ADDR_CLK, 32'h0);
        wr(ADDR_TIM, 32'h1f);
        tog(n);
        tog(n);
        chk("duty_clamp", n, half(0, 23, 0));
        wr(ADDR_TIM, 32'h317);
        tog(n);
        repeat (100) @(negedge core_clk);
        chk("seg_cut", seg_out[71:56], 0);
        wr(ADDR_TIM, 32'h307);
        tog(n);
        repeat (100) @(negedge core_clk);
        chk("seg_full", seg_out[71:40], 32'hffffffff);
        wr(ADDR_INTE, 32'h1);
        wr(ADDR_INTF, 32'h1);
        tog(n);
        tog(n);
        repeat (4) @(negedge core_clk);
        chk("irq_set", irq, 1);
        wr(ADDR_INTF, 32'h1);
        @(negedge core_clk);
        chk("irq_clr", irq, 0);
        wr(ADDR_INTE, 32'h0);
        tog(n);
        tog(n);
        repeat (4) @(negedge core_clk);
        chk("irq_mask", irq, 0);
        @(posedge core_clk);
        cpu_debug <= 1'b1;
        repeat (10) @(negedge core_clk);
        chk("com_blank", com_out, 0);
        fr = frame_monitor_out;
        repeat (600) @(negedge core_clk);
        chk("frame_hold", frame_monitor_out, fr);
        rdr(ADDR_STAT);
        chk("susp_on", rd[16], 1);
        rdr(ADDR_TIM);
        chk("tim_kept", rd, 32'h307);
        cpu_debug <= 1'b0;
        tog(n);
        tog(n);
        chk("resume", n, half(3, 7, 0));
        wr(ADDR_CLK, 32'h100);
        cpu_debug <= 1'b1;
        tog(n);
        tog(n);
        chk("dbg_run", n, half(3, 7, 0));
        rdr(ADDR_STAT);
        chk("susp_off", rd[16], 0);
        cpu_debug <= 1'b0;
        wr(ADDR_CLK, 32'h1);
        wr(ADDR_TIM, 32'h0);
        tog(n);
        tog(n);
        chk("src_32k", n, 4 * OP_PRESCALE);
        chk("one_com", multi_q, 0);
        finish_test();
    end
endmodule : tb_top
